// file: mmc_top.sv
// Behaviour
// - decode address with operating mode to resource
// - security state gates selection and data in special single chip mode
// - emulation chip select from address decode
// - external chip select on external accesses
// - no pins, only internal connections
// - ram position write once unless special
// - ram position write acts next cycle
// - ram position bits give base upper bits
// - ram alignment low or high in space
// - page index six bits, upper read zero
// - two read-only memory size registers
// - stretch external access 0 to 3 E clocks
// - eeprom enable removes or maps eeprom
// - register block base below 0x8000
// - program memory enable maps nonvolatile memory
`include "mmc_params.svh"
`default_nettype none
module mmc_top #(
  parameter int          RAM_SIZE  = 12288, // ram bytes
  parameter int          RAM_SPACE = 16384, // mappable ram space
  parameter int          EE_SIZE   = 2048,  // eeprom bytes
  parameter int          REG_SIZE  = 1024,  // register block bytes
  parameter logic [7:0]  SIZE_A    = 8'h00, // memory size code a
  parameter logic [7:0]  SIZE_B    = 8'h00  // memory size code b
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // avalon-mm register slave
  input  wire logic [5:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // internal links only
  // core side, same clock domain
  input  wire mmc_pkg::mmc_mode_t mode,
  input  wire logic [1:0]         sec_bits,
  input  wire mmc_pkg::mmc_core_req_t core_req,
  // decode results
  output mmc_pkg::mmc_sel_t       sel,
  output mmc_pkg::mmc_dbus_t      dbus_src,
  output logic [5:0]              flash_page,
  output logic                    emu_cs,
  output logic                    ext_cs_n,
  output logic                    core_hold,
  output logic                    secure
);
  import mmc_pkg::*;

  // register state
  logic [7:0] ram_pos_reg;      // ram base bits and alignment
  logic [7:0] reg_pos_reg;      // register block base bits
  logic [7:0] ee_pos_reg;       // eeprom base bits and enable
  logic [7:0] misc_reg;         // stretch and program memory control
  logic [5:0] page_reg;         // program page index
  logic       ram_wr_done_reg;  // first ram position write taken
  logic       reg_wr_done_reg;  // first register position write taken
  logic       misc_wr_done_reg; // first misc write taken
  logic       init_done_reg;    // mode-dependent reset applied
  logic       wait_reg;         // waitrequest flop

  // mode classes
  logic is_special;             // write protection lifted
  logic is_emul;                // emulation modes
  logic is_single;              // no external bus
  logic wr_acc;                 // write completes this edge
  logic sec_now;                // decoded security state

  always_comb begin
    is_special = (mode == MMC_SPEC_SINGLE) || (mode == MMC_SPEC_TEST)
              || (mode == MMC_PERIPH);
    is_emul    = (mode == MMC_EMU_NARROW) || (mode == MMC_EMU_WIDE);
    is_single  = (mode == MMC_SPEC_SINGLE) || (mode == MMC_NORM_SINGLE)
              || (mode == MMC_PERIPH);
    wr_acc     = write && !wait_reg;
    sec_now    = (sec_bits != 2'b10);
  end

  // bus handshake: one wait cycle, then done
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((read || write) && wait_reg);
    end
  end

  // read data captured during the wait cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && wait_reg) begin
      case (address)
        `MMC_OFS_RAM_POS: readdata <= {24'h000000,
                             ram_pos_reg[7:3], 2'b00, ram_pos_reg[0]};
        `MMC_OFS_REG_POS: readdata <= {24'h000000, 1'b0,
                             reg_pos_reg[6:3], 3'b000};
        `MMC_OFS_EE_POS:  readdata <= {24'h000000,
                             ee_pos_reg[7:3], 2'b00, ee_pos_reg[0]};
        `MMC_OFS_MISC:    readdata <= {28'h0000000, misc_reg[3:0]};
        `MMC_OFS_SIZE_A:  readdata <= {24'h000000, SIZE_A};
        `MMC_OFS_SIZE_B:  readdata <= {24'h000000, SIZE_B};
        `MMC_OFS_PAGE:    readdata <= {26'h0000000, page_reg};
        default:          readdata <= 32'h0000_0000;
      endcase
    end
  end

  // waitrequest straight from its flop
  always_comb waitrequest = wait_reg;

  // ram position, write once outside special modes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ram_pos_reg     <= `MMC_RST_RAM_POS;
      ram_wr_done_reg <= 1'b0;
    end else if (wr_acc && address == `MMC_OFS_RAM_POS) begin
      if (is_special || !ram_wr_done_reg) begin
        ram_pos_reg <= {writedata[7:3], 2'b00, writedata[0]};
      end
      ram_wr_done_reg <= 1'b1;
    end
  end

  // register block position, same write-once rule
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_pos_reg     <= `MMC_RST_REG_POS;
      reg_wr_done_reg <= 1'b0;
    end else if (wr_acc && address == `MMC_OFS_REG_POS) begin
      if (is_special || !reg_wr_done_reg) begin
        reg_pos_reg <= {1'b0, writedata[6:3], 3'b000};
      end
      reg_wr_done_reg <= 1'b1;
    end
  end

  // eeprom position, writable at any time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ee_pos_reg <= `MMC_RST_EE_POS;
    end else if (wr_acc && address == `MMC_OFS_EE_POS) begin
      ee_pos_reg <= {writedata[7:3], 2'b00, writedata[0]};
    end
  end

  // misc: reset value depends on mode, applied after release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      misc_reg         <= `MMC_RST_MISC;
      misc_wr_done_reg <= 1'b0;
      init_done_reg    <= 1'b0;
    end else if (!init_done_reg) begin
      // mode pins are only valid once reset has released
      init_done_reg <= 1'b1;
      if (mode == MMC_SPEC_TEST) begin
        misc_reg <= `MMC_RST_MISC_TEST;
      end
    end else if (wr_acc && address == `MMC_OFS_MISC) begin
      if (is_special || !misc_wr_done_reg) begin
        misc_reg <= {4'h0, writedata[3:0]};
      end
      misc_wr_done_reg <= 1'b1;
    end
  end

  // program page index
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      page_reg <= `MMC_RST_PAGE;
    end else if (wr_acc && address == `MMC_OFS_PAGE) begin
      page_reg <= writedata[5:0];
    end
  end

  // address decode; registers are read from flops, so any
  // write shows in the decode one cycle later
  logic [15:0] a;          // core address
  logic [15:0] ram_base;   // ram position base
  logic [15:0] ram_space;  // aligned start of ram space
  logic [15:0] ram_ofs;    // offset inside ram space
  logic [15:0] reg_base;   // register block base
  logic [15:0] ee_base;    // eeprom base
  logic        hit_reg;    // register block hit
  logic        hit_ee;     // eeprom hit
  logic        hit_ram;    // ram hit
  logic        hit_fl;     // flash hit
  logic        in_window;  // paging window
  mmc_sel_t    sel_next;   // selection for this access
  mmc_dbus_t   db_next;    // data source for this access
  logic [5:0]  page_next;  // physical flash page

  always_comb begin
    a         = core_req.addr;
    ram_base  = {ram_pos_reg[7:3], 11'h000};
    ram_space = ram_base & ~16'(RAM_SPACE - 1);
    ram_ofs   = a - ram_space;
    reg_base  = {1'b0, reg_pos_reg[6:3], 11'h000};
    ee_base   = {ee_pos_reg[7:3], 11'h000};
    hit_reg   = (a - reg_base) < 16'(REG_SIZE);
    hit_ee    = ee_pos_reg[`MMC_EEPROM_ENABLE_BIT]
             && ((a - ee_base) < 16'(EE_SIZE));
    hit_ram   = (a & ~16'(RAM_SPACE - 1)) == ram_space;
    if (ram_pos_reg[`MMC_RAM_HAL_BIT]) begin
      hit_ram = hit_ram && (ram_ofs >= 16'(RAM_SPACE - RAM_SIZE));
    end else begin
      hit_ram = hit_ram && (ram_ofs < 16'(RAM_SIZE));
    end
    hit_fl    = misc_reg[`MMC_PROGRAM_MEMORY_ENABLE_BIT] && (a[15:14] != 2'b00)
             && !(misc_reg[`MMC_PROGRAM_MEMORY_UPPER_ONLY_BIT] && a[15:14] == 2'b01);
    in_window = a[15:14] == 2'b10;
    // secure special single chip hides eeprom and flash
    if (sec_now && mode == MMC_SPEC_SINGLE) begin
      hit_ee = 1'b0;
      hit_fl = 1'b0;
    end
    sel_next = '0;
    db_next  = MMC_DB_NONE;
    if (!core_req.valid) begin
      sel_next = '0;
    end else if (hit_reg) begin
      sel_next.regs = 1'b1;
      db_next       = MMC_DB_REGS;
    end else if (hit_ee) begin
      sel_next.eeprom = 1'b1;
      db_next         = MMC_DB_EEPROM;
    end else if (hit_ram) begin
      sel_next.ram = 1'b1;
      db_next      = MMC_DB_RAM;
    end else if (hit_fl) begin
      sel_next.flash = 1'b1;
      db_next        = MMC_DB_FLASH;
    end else if (!is_single) begin
      sel_next.ext = 1'b1;
      db_next      = MMC_DB_EXT;
    end
    // window shows selected page, fixed pages elsewhere
    if (in_window) begin
      page_next = page_reg;
    end else if (a[15:14] == 2'b01) begin
      page_next = `MMC_PAGE_FIX_LO;
    end else begin
      page_next = `MMC_PAGE_FIX_HI;
    end
  end

  // registered decode outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel        <= '0;
      dbus_src   <= MMC_DB_NONE;
      flash_page <= 6'h00;
      emu_cs     <= 1'b0;
      ext_cs_n   <= 1'b1;
      secure     <= 1'b1;
    end else begin
      sel        <= sel_next;
      dbus_src   <= db_next;
      flash_page <= page_next;
      secure     <= sec_now;
      emu_cs     <= is_emul && sel_next.flash;
      ext_cs_n   <= !sel_next.ext;
    end
  end

  // e clock enable divider
  logic [3:0] ediv_reg;    // divider count
  logic       e_en;        // one pulse per e clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ediv_reg <= 4'h0;
    end else if (ediv_reg == `MMC_E_DIV - 4'h1) begin
      ediv_reg <= 4'h0;
    end else begin
      ediv_reg <= ediv_reg + 4'h1;
    end
  end
  always_comb e_en = (ediv_reg == `MMC_E_DIV - 4'h1);

  // external stretch: hold the core for 0..3 e clocks
  mmc_st_t    st_reg;      // stretch state
  logic [1:0] str_cnt_reg; // e clocks still to stretch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg      <= MMC_ST_IDLE;
      str_cnt_reg <= 2'b00;
      core_hold   <= 1'b0;
    end else begin
      case (st_reg)
        MMC_ST_IDLE: begin
          if (sel_next.ext && misc_reg[3:2] != 2'b00) begin
            st_reg      <= MMC_ST_STRETCH;
            str_cnt_reg <= misc_reg[3:2];
            core_hold   <= 1'b1;
          end
        end
        MMC_ST_STRETCH: begin
          if (e_en) begin
            if (str_cnt_reg == 2'b01) begin
              st_reg    <= MMC_ST_IDLE;
              core_hold <= 1'b0;
            end
            str_cnt_reg <= str_cnt_reg - 2'b01;
          end
        end
        default: begin
          st_reg    <= MMC_ST_IDLE;
          core_hold <= 1'b0;
        end
      endcase
    end
  end
endmodule : mmc_top
`default_nettype wire

// file: mmc_params.svh
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH
// register byte offsets on the slave bus
`define MMC_OFS_RAM_POS   6'h00
`define MMC_OFS_REG_POS   6'h04
`define MMC_OFS_EE_POS    6'h08
`define MMC_OFS_MISC      6'h0C
`define MMC_OFS_TEST_A    6'h10
`define MMC_OFS_TEST_B    6'h14
`define MMC_OFS_SIZE_A    6'h18
`define MMC_OFS_SIZE_B    6'h1C
`define MMC_OFS_PAGE      6'h20
// field positions
`define MMC_POS_HI        7
`define MMC_POS_LO        3
`define MMC_RAM_HAL_BIT   0
`define MMC_EEPROM_ENABLE_BIT      0
`define MMC_PROGRAM_MEMORY_ENABLE_BIT     0
`define MMC_PROGRAM_MEMORY_UPPER_ONLY_BIT     1
`define MMC_STR_LO        2
// reset values
`define MMC_RST_RAM_POS   8'h08
`define MMC_RST_REG_POS   8'h00
`define MMC_RST_EE_POS    8'h11
`define MMC_RST_MISC      8'h0D
`define MMC_RST_MISC_TEST 8'h0C
`define MMC_RST_PAGE      6'h00
// fixed flash pages seen outside the paging window
`define MMC_PAGE_FIX_LO   6'h3E
`define MMC_PAGE_FIX_HI   6'h3F
// core clocks per E clock
`define MMC_E_DIV         4'h2
`endif

// file: mmc_pkg.sv
`default_nettype none
package mmc_pkg;
  // system operating modes
  typedef enum logic [2:0] {
    MMC_SPEC_SINGLE, MMC_EMU_NARROW, MMC_SPEC_TEST, MMC_EMU_WIDE,
    MMC_NORM_SINGLE, MMC_NORM_NARROW, MMC_PERIPH, MMC_NORM_WIDE
  } mmc_mode_t;
  // one-hot resource selection for a core access
  typedef struct packed {
    logic regs;
    logic eeprom;
    logic ram;
    logic flash;
    logic ext;
  } mmc_sel_t;
  // core access request
  typedef struct packed {
    logic        valid;
    logic        rw;
    logic [15:0] addr;
  } mmc_core_req_t;
  // core data bus source
  typedef enum logic [2:0] {
    MMC_DB_NONE, MMC_DB_REGS, MMC_DB_EEPROM, MMC_DB_RAM,
    MMC_DB_FLASH, MMC_DB_EXT
  } mmc_dbus_t;
  // stretch sequencer
  typedef enum logic {MMC_ST_IDLE, MMC_ST_STRETCH} mmc_st_t;
endpackage : mmc_pkg
`default_nettype wire

// file: mmc_top_monitor.sv
`include "mmc_params.svh"
`default_nettype none
module mmc_top_monitor (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rstn,
  // register bus
  input wire logic [5:0]             address,
  input wire logic                   read,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  // core side
  input wire mmc_pkg::mmc_mode_t     mode,
  input wire logic [1:0]             sec_bits,
  input wire mmc_pkg::mmc_core_req_t core_req,
  input wire mmc_pkg::mmc_sel_t      sel,
  input wire logic                   emu_cs,
  input wire logic                   ext_cs_n,
  input wire logic                   core_hold,
  input wire logic                   secure
);
  timeunit 1ns;
  timeprecision 1ns;
  import mmc_pkg::*;
  // one domain, so one clock and one reset for all
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_wait_once: assert property (
    $fell(waitrequest) |=> waitrequest) else $error("wait low twice");
  a_idle_none: assert property (
    !core_req.valid |=> sel == 5'h00) else $error("select while idle");
  a_single_no_ext: assert property (
    mode inside {MMC_SPEC_SINGLE, MMC_NORM_SINGLE, MMC_PERIPH}
    |=> !sel.ext) else $error("external in single chip");
  a_ext_select: assert property (
    ext_cs_n != sel.ext) else $error("external select wrong");
  a_emu_select: assert property (
    $past(rstn) |-> emu_cs == (sel.flash
    && $past(mode) inside {MMC_EMU_NARROW, MMC_EMU_WIDE}))
    else $error("emulation select wrong");
  a_secure_code: assert property (
    $past(rstn) |-> secure == ($past(sec_bits) != 2'h2))
    else $error("security decode wrong");
  a_secure_hide: assert property (
    secure && $past(mode) == MMC_SPEC_SINGLE |-> !sel.eeprom && !sel.flash)
    else $error("secured memory visible");
  // stretch only on external, at most three e clocks
  a_hold_bound: assert property (
    $rose(core_hold) |-> !ext_cs_n ##[1:7] !core_hold)
    else $error("stretch wrong");
  a_page_upper: assert property (
    read && !waitrequest && address == `MMC_OFS_PAGE |->
    readdata[7:6] == 2'h0) else $error("page upper bits set");
endmodule : mmc_top_monitor
bind mmc_top mmc_top_monitor mon_u (
  .clock, .rstn, .address, .read, .readdata, .waitrequest, .mode,
  .sec_bits, .core_req, .sel, .emu_cs, .ext_cs_n, .core_hold, .secure
);
`default_nettype wire

// file: mmc_core_model.sv
`default_nettype none
module mmc_core_model (
  // core clock
  input  wire logic                  clock,
  // stretch from the decoder
  input  wire logic                  core_hold,
  // access toward the decoder
  output var mmc_pkg::mmc_core_req_t core_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import mmc_pkg::*;
  // idle at time zero
  initial core_req = '{1'b0, 1'b1, 16'hFFFF};
  // one read cycle; address flips when idle so stale values never match
  task automatic access(input logic [15:0] a);
    int n;
    n = 0;
    while (core_hold !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    core_req <= '{1'b1, 1'b1, a};
    @(posedge clock);
    core_req <= '{1'b0, 1'b1, ~a};
  endtask : access
endmodule : mmc_core_model
`default_nettype wire

// file: memory_map_control_tb.sv
`include "mmc_params.svh"
`default_nettype none
module memory_map_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mmc_pkg::*;
  // stimulus
  logic          clock = 1'b0;
  logic          rstn = 1'b0;
  logic [5:0]    address = 6'h00;
  logic          read = 1'b0;
  logic          write = 1'b0;
  logic [31:0]   writedata = 32'h0;
  mmc_mode_t     mode = MMC_NORM_WIDE;
  logic [1:0]    sec_bits = 2'h2;
  // design outputs
  logic [31:0]   readdata;
  logic          waitrequest;
  mmc_core_req_t core_req;
  mmc_sel_t      sel;
  mmc_dbus_t     dbus_src;
  logic [5:0]    flash_page;
  logic          emu_cs, ext_cs_n, core_hold, secure;
  // bookkeeping
  int            failures = 0;
  int            checked = 0;
  int            held;
  logic [5:0]    program_page_index;
  logic [31:0]   q;
  logic [5:0]    ofs [10] = '{`MMC_OFS_RAM_POS, `MMC_OFS_REG_POS,
    `MMC_OFS_EE_POS, `MMC_OFS_MISC, `MMC_OFS_TEST_A, `MMC_OFS_TEST_B,
    `MMC_OFS_SIZE_A, `MMC_OFS_SIZE_B, `MMC_OFS_PAGE, 6'h3C};
  logic [7:0]    rst [10] = '{`MMC_RST_RAM_POS, `MMC_RST_REG_POS,
    `MMC_RST_EE_POS, `MMC_RST_MISC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // 100 ns clock
  always #50 clock = ~clock;
  mmc_top dut_u (.clock, .rstn, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .mode, .sec_bits, .core_req, .sel, .dbus_src,
    .flash_page, .emu_cs, .ext_cs_n, .core_hold, .secure);
  mmc_core_model core_u (.clock, .core_hold, .core_req);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // one transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    if (n >= 20) failures++;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(q, {24'h0, e});
  endtask : rd
  // expected page for an address
  function automatic logic [5:0] pg(input logic [15:0] a);
    if (a[15:14] == 2'h2)
      return program_page_index;
    return (a[15:14] == 2'h1) ? `MMC_PAGE_FIX_LO : `MMC_PAGE_FIX_HI;
  endfunction : pg
  // expected data source, following the select priority
  function automatic mmc_dbus_t db_of(input mmc_sel_t s);
    if (s.regs) return MMC_DB_REGS;
    if (s.eeprom) return MMC_DB_EEPROM;
    if (s.ram) return MMC_DB_RAM;
    if (s.flash) return MMC_DB_FLASH;
    if (s.ext) return MMC_DB_EXT;
    return MMC_DB_NONE;
  endfunction : db_of
  // one core access, then every decode output and the stretch length
  task automatic probe(input logic [15:0] a, input mmc_sel_t es);
    core_u.access(a);
    @(negedge clock);
    check(sel, es);
    check(dbus_src, db_of(es));
    check(ext_cs_n, !es.ext);
    check(emu_cs, es.flash
          && mode inside {MMC_EMU_NARROW, MMC_EMU_WIDE});
    check(flash_page, pg(a));
    check(secure, sec_bits != 2'h2);
    held = 0;
    while (core_hold === 1'b1 && held < 9) begin
      @(negedge clock);
      held++;
    end
    @(posedge clock);
  endtask : probe
  task automatic reset_dut();
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    program_page_index = 6'h00;
    repeat (2) @(posedge clock);
  endtask : reset_dut
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (4000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    reset_dut();
    wr(`MMC_OFS_TEST_A, 8'hFF);
    wr(`MMC_OFS_SIZE_A, 8'hFF);
    foreach (ofs[i]) rd(ofs[i], rst[i]);
    done("reset values");
    probe(16'h0100, 5'h10);
    probe(16'h1000, 5'h08);
    probe(16'h2000, 5'h04);
    probe(16'h3000, 5'h01);
    check(held >= 5 && held <= 6, 1'b1);
    probe(16'h4000, 5'h02);
    wr(`MMC_OFS_RAM_POS, 8'h09);
    wr(`MMC_OFS_RAM_POS, 8'h08);
    rd(`MMC_OFS_RAM_POS, 8'h09);
    probe(16'h3000, 5'h04);
    wr(`MMC_OFS_MISC, 8'h01);
    wr(`MMC_OFS_MISC, 8'h0D);
    rd(`MMC_OFS_MISC, 8'h01);
    probe(16'h0800, 5'h01);
    check(held, 0);
    wr(`MMC_OFS_EE_POS, 8'h10);
    probe(16'h1000, 5'h04);
    wr(`MMC_OFS_PAGE, 8'hE5);
    rd(`MMC_OFS_PAGE, 8'h25);
    program_page_index = 6'h25;
    probe(16'h8000, 5'h02);
    done("normal mode");
    mode <= MMC_SPEC_TEST;
    reset_dut();
    rd(`MMC_OFS_MISC, 8'h0C);
    probe(16'h8000, 5'h01);
    for (int s = 0; s < 4; s++) begin
      wr(`MMC_OFS_MISC, 8'(s * 4));
      probe(16'h3000, 5'h01);
      check(held + 1 >= 2 * s && held <= 2 * s, 1'b1);
    end
    rd(`MMC_OFS_MISC, 8'h0C);
    wr(`MMC_OFS_REG_POS, 8'hF8);
    rd(`MMC_OFS_REG_POS, 8'h78);
    probe(16'h7800, 5'h10);
    wr(`MMC_OFS_RAM_POS, 8'h89);
    // core samples on the write edge: old decode must still apply
    fork
      wr(`MMC_OFS_RAM_POS, 8'h88);
      begin
        @(posedge clock);
        core_u.access(16'h8000);
        @(negedge clock);
        check(sel, 5'h01);
      end
    join
    probe(16'h8000, 5'h04);
    wr(`MMC_OFS_MISC, 8'h01);
    mode <= MMC_EMU_WIDE;
    probe(16'hC000, 5'h02);
    mode <= MMC_SPEC_SINGLE;
    sec_bits <= 2'h0;
    probe(16'hC000, 5'h00);
    sec_bits <= 2'h2;
    probe(16'hC000, 5'h02);
    probe(16'h3000, 5'h00);
    done("special modes");
    report_and_stop();
  end
endmodule : memory_map_control_tb
`default_nettype wire
